// >>> rtl/serial_port_ctrl.sv
// Digital control of a programmable multi-protocol serial line interface.
`timescale 1ns/1ps
module serial_port_ctrl
  import serial_port_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Microprocessor port.
  input  wire logic [3:0] addr,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe_n,
  input  wire logic       chipSelect_n,
  input  wire logic       readStrobe_n,
  input  wire logic       write_strobe_n,
  output logic            intReq_n,
  // Mode source select and external modes.
  input  wire logic       external_control_select,
  input  wire logic [7:0] extOutMode,
  // TTL side.
  input  wire logic       txData,
  input  wire logic       txClkIn,
  output logic            txClkOut,
  output logic            txClkOe_n,
  input  wire logic       reqSend,
  input  wire logic       termReady,
  input  wire logic       remLoop,
  input  wire logic       locLoop,
  output logic            rxData,
  output logic            rxClk,
  output logic            clrSend,
  output logic            dataSetReady,
  output logic            carrierDetect,
  output logic            ringIn,
  // Line side drivers: a inverted, b true, low-active enables.
  output logic            sendDataA,
  output logic            sendDataB,
  output logic            sendDataOe_n,
  output logic            termTimA,
  output logic            termTimB,
  output logic            termTimOe_n,
  input  wire logic       termTimInB,
  output logic            adapter_config_clock_out,
  output logic            sendTimB,
  output logic            sendTimOe_n,
  input  wire logic       adapter_serial_data_in,
  output logic      [3:0] ctrlA,
  output logic      [3:0] ctrlB,
  output logic            ctrlOe_n,
  // Line side receivers, b-line true sense.
  input  wire logic       rxDataB,
  input  wire logic       rxTimB,
  input  wire logic [3:0] statB,
  // Level class per driver: data, clock, RS, TR, RL, LL.
  output logic      [1:0] lvlData,
  output logic      [1:0] lvlClk,
  output logic      [1:0] lvlReqSend,
  output logic      [1:0] lvlTermRdy,
  output logic      [1:0] lvlRemLoop,
  output logic      [1:0] lvlLocLoop
);
  logic [7:0] outModeReg;
  logic [7:0] inModeReg;
  logic [7:0] configReg;
  logic [7:0] lineCfgReg;
  logic [7:0] ctrlValReg [4];
  logic [3:0] causeReg;
  logic [3:0] maskReg;
  logic       modeWrittenReg;
  logic       wrPrevReg;
  logic [9:0] pinRaw;
  logic [9:0] pinSync;
  logic       txDataSync, txClkSync, reqSendSync, termRdySync, remLoopSync;
  logic       locLoopSync, rxDataSync, rxTimSync, termTimSync, adapterDataSync;
  logic [3:0] statSync;
  logic [3:0] statChg;
  logic       csSync;
  logic       rdSync;
  logic       wrSync;
  logic       rdActive;
  logic       wrPulse;
  logic [7:0] effMode;
  logic [3:0] ctrlSrc;
  logic       driversOn;
  logic [7:0] readMux;

  // Host strobes pass two flip-flops before use.
  sync_edge csS (.clk_sys(clk_sys), .rst_n(rst_n), .resetLevel(1'b1), .asyncIn(chipSelect_n),
                 .syncOut(csSync), .changed());
  sync_edge rdS (.clk_sys(clk_sys), .rst_n(rst_n), .resetLevel(1'b1), .asyncIn(readStrobe_n),
                 .syncOut(rdSync), .changed());
  sync_edge wrS (.clk_sys(clk_sys), .rst_n(rst_n), .resetLevel(1'b1), .asyncIn(write_strobe_n),
                 .syncOut(wrSync), .changed());

  // Status inputs are synchronised and watched for changes.
  for (genvar i = 0; i < 4; i++) begin : gStat
    sync_edge stS (.clk_sys(clk_sys), .rst_n(rst_n), .resetLevel(1'b0), .asyncIn(statB[i]),
                   .syncOut(statSync[i]), .changed(statChg[i]));
  end

  // Line and TTL pins pass two flip-flops before any logic reads them.
  assign pinRaw = {adapter_serial_data_in, termTimInB, rxTimB, rxDataB, locLoop, remLoop, termReady, reqSend,
                   txClkIn, txData};
  for (genvar i = 0; i < 10; i++) begin : gPin
    sync_edge pnS (.clk_sys(clk_sys), .rst_n(rst_n), .resetLevel(1'b0), .asyncIn(pinRaw[i]),
                   .syncOut(pinSync[i]), .changed());
  end
  assign {adapterDataSync, termTimSync, rxTimSync, rxDataSync, locLoopSync, remLoopSync, termRdySync,
          reqSendSync, txClkSync, txDataSync} = pinSync;

  assign rdActive = !csSync && !rdSync;
  assign wrPulse  = !csSync && !wrSync && wrPrevReg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPrevReg <= 1'b1;
    end else begin
      wrPrevReg <= wrSync || csSync;
    end
  end

  // Register writes at the addressed index.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      outModeReg     <= RESET_BYTE;
      inModeReg      <= RESET_BYTE;
      configReg      <= RESET_BYTE;
      lineCfgReg     <= RESET_BYTE;
      maskReg        <= 4'h0;
      modeWrittenReg <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        ctrlValReg[k] <= RESET_BYTE;
      end
    end else if (wrPulse) begin
      case (addr)
        ADDR_OUT_MODE: begin
          outModeReg     <= dataIn;
          modeWrittenReg <= 1'b1;
        end
        ADDR_IN_MODE:   inModeReg    <= dataIn;
        ADDR_CONFIG:    configReg    <= dataIn;
        ADDR_INT_CAUSE: maskReg      <= dataIn[3:0];
        ADDR_LINE_CFG:  lineCfgReg   <= dataIn;
        ADDR_TERM_RDY:  ctrlValReg[1] <= dataIn;
        ADDR_REQ_SEND:  ctrlValReg[0] <= dataIn;
        ADDR_REM_LOOP:  ctrlValReg[2] <= dataIn;
        ADDR_LOC_LOOP:  ctrlValReg[3] <= dataIn;
        default: ;
      endcase
    end
  end

  // Interrupt causes: a change sets its bit, and a set wins over a clear.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      causeReg <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (statChg[k]) begin
          causeReg[k] <= 1'b1;
        end else if (wrPulse && addr == ADDR_INT_CAUSE && dataIn[k + 4]) begin
          causeReg[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      intReq_n <= 1'b1;
    end else begin
      intReq_n <= !(|(causeReg & maskReg));
    end
  end

  // Read multiplexer and bus drive.
  always_comb begin
    case (addr)
      ADDR_OUT_MODE:  readMux = outModeReg & READ_MASK_OUT_MODE;
      ADDR_IN_MODE:   readMux = inModeReg;
      ADDR_CONFIG:    readMux = configReg;
      ADDR_LINE_STAT: readMux = {3'h0, adapterDataSync, statSync};
      ADDR_INT_CAUSE: readMux = {4'h0, causeReg};
      ADDR_LINE_CFG:  readMux = lineCfgReg;
      ADDR_TERM_RDY:  readMux = ctrlValReg[1];
      ADDR_REQ_SEND:  readMux = ctrlValReg[0];
      ADDR_REM_LOOP:  readMux = ctrlValReg[2];
      ADDR_LOC_LOOP:  readMux = ctrlValReg[3];
      default:        readMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dataOut  <= 8'h00;
      dataOe_n <= 1'b1;
    end else begin
      dataOut  <= readMux;
      dataOe_n <= !rdActive;
    end
  end

  // Mode source and level classes.
  assign effMode = external_control_select ? extOutMode : outModeReg;

  always_comb begin
    lvlData    = LVL_OFF;
    lvlReqSend = LVL_OFF;
    lvlRemLoop = LVL_OFF;
    case (effMode[3:0])
      PROTO_RS232, PROTO_EIA562, PROTO_MIL188C: begin
        lvlData    = LVL_RS232;
        lvlReqSend = LVL_RS232;
        lvlRemLoop = LVL_RS232;
      end
      PROTO_RS422, PROTO_RS485, PROTO_MILBAL: begin
        lvlData    = LVL_RS422;
        lvlReqSend = LVL_RS422;
        lvlRemLoop = LVL_RS422;
      end
      PROTO_RS423, PROTO_MILUNB: begin
        lvlData    = LVL_RS423;
        lvlReqSend = LVL_RS423;
        lvlRemLoop = LVL_RS423;
      end
      PROTO_RS449, PROTO_EIA530: begin
        lvlData    = LVL_RS422;
        lvlReqSend = LVL_RS422;
        lvlRemLoop = LVL_RS423;
      end
      PROTO_V35: begin
        lvlData    = LVL_RS422;
        lvlReqSend = LVL_RS232;
        lvlRemLoop = LVL_RS232;
      end
      default: ;
    endcase
  end
  assign lvlClk     = lvlData;
  assign lvlTermRdy = lvlReqSend;
  assign lvlLocLoop = lvlRemLoop;

  // Control pair sources: pin or register, chosen per line.
  assign ctrlSrc = {lineCfgReg[3] ? ctrlValReg[3][0] : locLoopSync,
                    lineCfgReg[2] ? ctrlValReg[2][0] : remLoopSync,
                    lineCfgReg[1] ? ctrlValReg[1][0] : termRdySync,
                    lineCfgReg[0] ? ctrlValReg[0][0] : reqSendSync};

  // Driver enable: written mode, general enable, continuous or terminal ready.
  assign driversOn = (modeWrittenReg || external_control_select) && configReg[CONFIG_OUT_EN]
                     && (effMode[3:0] != PROTO_OFF)
                     && (effMode[CONTINUOUS_BIT] || ctrlSrc[1]);

  // Line drive: a inverted, b true.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sendDataA <= 1'b1;
      sendDataB <= 1'b0;
      ctrlA     <= 4'hF;
      ctrlB     <= 4'h0;
      termTimA  <= 1'b1;
      termTimB  <= 1'b0;
      sendTimB  <= 1'b0;
      adapter_config_clock_out <= 1'b1;
      txClkOut  <= 1'b0;
    end else begin
      sendDataA <= !txDataSync;
      sendDataB <= txDataSync;
      ctrlA     <= ~ctrlSrc;
      ctrlB     <= ctrlSrc;
      termTimA  <= !txClkSync;
      termTimB  <= txClkSync;
      adapter_config_clock_out <= inModeReg[7] ? configReg[7] : !txClkSync;
      sendTimB  <= txClkSync;
      txClkOut  <= termTimSync;
    end
  end

  // Clock direction: inModeReg bit 6 set makes the terminal timing pair an input.
  assign txClkOe_n    = !inModeReg[6];
  assign termTimOe_n  = !(driversOn && !inModeReg[6]);
  assign sendTimOe_n  = !(driversOn && !inModeReg[7]);
  assign sendDataOe_n = !driversOn;
  assign ctrlOe_n     = !driversOn;

  // Receivers to TTL outputs.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxData        <= 1'b0;
      rxClk         <= 1'b0;
      clrSend       <= 1'b0;
      dataSetReady  <= 1'b0;
      carrierDetect <= 1'b0;
      ringIn        <= 1'b0;
    end else begin
      rxData        <= rxDataSync;
      rxClk         <= rxTimSync;
      clrSend       <= statSync[0];
      dataSetReady  <= statSync[1];
      carrierDetect <= statSync[2];
      ringIn        <= statSync[3];
    end
  end
endmodule : serial_port_ctrl

// >>> rtl/serial_port_pkg.sv
// Constants shared by the serial port control design.
package serial_port_pkg;
  // Register indices on the 4-bit address bus.
  localparam logic [3:0] ADDR_OUT_MODE   = 4'h0;
  localparam logic [3:0] ADDR_IN_MODE    = 4'h1;
  localparam logic [3:0] ADDR_CONFIG     = 4'h2;
  localparam logic [3:0] ADDR_LINE_STAT  = 4'h3;
  localparam logic [3:0] ADDR_INT_CAUSE  = 4'h4;
  localparam logic [3:0] ADDR_LINE_CFG   = 4'h5;
  localparam logic [3:0] ADDR_TERM_RDY   = 4'h6;
  localparam logic [3:0] ADDR_REQ_SEND   = 4'h7;
  localparam logic [3:0] ADDR_REM_LOOP   = 4'h8;
  localparam logic [3:0] ADDR_LOC_LOOP   = 4'h9;
  // Field positions.
  localparam int CONTINUOUS_BIT = 7;
  localparam int CONFIG_OUT_EN  = 0;
  // Protocol codes in the low nibble of the output mode register.
  localparam logic [3:0] PROTO_OFF     = 4'h0;
  localparam logic [3:0] PROTO_MIL188C = 4'h1;
  localparam logic [3:0] PROTO_RS232   = 4'h2;
  localparam logic [3:0] PROTO_EIA562  = 4'h3;
  localparam logic [3:0] PROTO_RS422   = 4'h4;
  localparam logic [3:0] PROTO_RS485   = 4'h5;
  localparam logic [3:0] PROTO_MILBAL  = 4'h6;
  localparam logic [3:0] PROTO_RS423   = 4'h8;
  localparam logic [3:0] PROTO_MILUNB  = 4'h9;
  localparam logic [3:0] PROTO_RS449   = 4'hC;
  localparam logic [3:0] PROTO_EIA530  = 4'hD;
  localparam logic [3:0] PROTO_V35     = 4'hE;
  // Electrical level classes, two bits per driver.
  localparam logic [1:0] LVL_OFF    = 2'h0;
  localparam logic [1:0] LVL_RS232  = 2'h1;
  localparam logic [1:0] LVL_RS422  = 2'h2;
  localparam logic [1:0] LVL_RS423  = 2'h3;
  // Reset value and output mode read mask.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_MASK_OUT_MODE = 8'h8F;
endpackage : serial_port_pkg

// >>> rtl/sync_edge.sv
// Two flip-flop synchroniser with a change detector on the settled copy.
`timescale 1ns/1ps
module sync_edge (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic resetLevel,
  // Asynchronous level in, settled level and change pulse out.
  input  wire logic asyncIn,
  output logic      syncOut,
  output logic      changed
);
  logic metaReg;
  logic syncReg;
  logic lastReg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Flops rest at the pin's idle level so that no false strobe or change follows reset.
      metaReg <= resetLevel;
      syncReg <= resetLevel;
      lastReg <= resetLevel;
    end else begin
      metaReg <= asyncIn;
      syncReg <= metaReg;
      lastReg <= syncReg;
    end
  end

  assign syncOut = syncReg;
  assign changed = (syncReg != lastReg);
endmodule : sync_edge

// >>> test/serial_port_ctrl_checker.sv
// Port-level assertions for the serial port control block.
`timescale 1ns/1ps
module serial_port_ctrl_checker
  import serial_port_pkg::*;
(
  // Clock and reset.
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Register port.
  input wire logic [3:0] addr,
  input wire logic       chipSelect_n,
  input wire logic       readStrobe_n,
  input wire logic       write_strobe_n,
  input wire logic       dataOe_n,
  input wire logic       intReq_n,
  // Mode source.
  input wire logic       external_control_select,
  input wire logic [7:0] extOutMode,
  // Line side.
  input wire logic       txData,
  input wire logic       txClkIn,
  input wire logic       termTimA,
  input wire logic       termTimB,
  input wire logic       sendTimB,
  input wire logic       termTimInB,
  input wire logic       txClkOut,
  input wire logic       sendDataA,
  input wire logic       sendDataB,
  input wire logic       sendDataOe_n,
  input wire logic       ctrlOe_n,
  input wire logic       rxDataB,
  input wire logic       rxData,
  input wire logic [3:0] statB,
  input wire logic       clrSend,
  input wire logic       dataSetReady,
  input wire logic       carrierDetect,
  input wire logic       ringIn
);
  logic modeWr_reg;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Notes the first host write of the output mode register since reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      modeWr_reg <= 1'h0;
    end else if (!chipSelect_n && !write_strobe_n && addr == ADDR_OUT_MODE) begin
      modeWr_reg <= 1'h1;
    end
  end
  sequence s_read;
    (!chipSelect_n && !readStrobe_n)[*5];
  endsequence
  property p_send_data;
    ($past(rst_n, 4) && $stable(txData))[*3] |-> sendDataB == txData && sendDataA == !txData;
  endproperty
  a_send_data: assert property (p_send_data) else $error("send data pair wrong");
  property p_term_tim;
    ($past(rst_n, 4) && $stable(txClkIn))[*3] |->
      termTimB == txClkIn && termTimA == !txClkIn && sendTimB == txClkIn;
  endproperty
  a_term_tim: assert property (p_term_tim) else $error("transmit timing pairs wrong");
  property p_clk_in;
    ($past(rst_n, 4) && $stable(termTimInB))[*4] |-> txClkOut == termTimInB;
  endproperty
  a_clk_in: assert property (p_clk_in) else $error("transmit clock input path wrong");
  property p_rx_data;
    ($past(rst_n, 4) && $stable(rxDataB))[*4] |-> rxData == rxDataB;
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("receive data wrong");
  property p_status;
    ($past(rst_n, 4) && $stable(statB))[*4] |-> {ringIn, carrierDetect, dataSetReady, clrSend} == statB;
  endproperty
  a_status: assert property (p_status) else $error("status outputs wrong");
  property p_reset;
    disable iff (1'h0) !rst_n |=> sendDataOe_n && ctrlOe_n && dataOe_n && intReq_n;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_mode_gate;
    !modeWr_reg && !external_control_select |-> sendDataOe_n && ctrlOe_n;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("driver on before mode write");
  property p_ext_off;
    (external_control_select && extOutMode[3:0] == PROTO_OFF)[*3] |-> sendDataOe_n && ctrlOe_n;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("external off mode ignored");
  property p_read;
    s_read |-> !dataOe_n;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_no_cs;
    chipSelect_n[*6] |-> dataOe_n;
  endproperty
  a_no_cs: assert property (p_no_cs) else $error("bus driven without select");
endmodule : serial_port_ctrl_checker

bind serial_port_ctrl serial_port_ctrl_checker chk_u (.*);

// >>> test/line_partner.sv
// Remote equipment model sending framed receive data with its own timing clock.
`timescale 1ns/1ps
module line_partner (
  // Frame request.
  input  wire logic       go,
  input  wire logic [7:0] byteIn,
  input  wire logic [3:0] statIn,
  // Line side.
  output logic            rxDataB,
  output logic            rxTimB,
  output logic            termTimInB,
  output logic [3:0]      statB,
  output logic            busy
);
  initial begin
    rxDataB = 1'h0;
    rxTimB = 1'h0;
    busy = 1'h0;
  end
  assign statB = statIn;
  assign termTimInB = rxTimB;
  // The timing clock runs only within a frame; the data line flips once the frame ends.
  always @(posedge go) begin
    busy = 1'h1;
    for (int i = 7; i >= 0; i--) begin
      rxDataB = byteIn[i];
      #80 rxTimB = 1'h1;
      #80 rxTimB = 1'h0;
    end
    rxDataB = !rxDataB;
    busy = 1'h0;
  end
endmodule : line_partner

// >>> test/tb_serial_port_ctrl.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
module tb_serial_port_ctrl
  import serial_port_pkg::*;
;
  logic       clk_sys = 1'h0, rst_n = 1'h0, chipSelect_n = 1'h1, readStrobe_n = 1'h1, write_strobe_n = 1'h1;
  logic       external_control_select = 1'h0, txData = 1'h0, txClkIn = 1'h0, reqSend = 1'h0, go = 1'h0;
  logic       termReady = 1'h0, remLoop = 1'h0, locLoop = 1'h0, adapter_serial_data_in = 1'h0;
  logic [3:0] addr = 4'h0, statIn = 4'h0, ctrlA, ctrlB, statB;
  logic [7:0] dataIn = 8'h00, extOutMode = 8'h00, byteIn = 8'h00, dataOut, r;
  logic [1:0] lvlData, lvlClk, lvlReqSend, lvlTermRdy, lvlRemLoop, lvlLocLoop;
  logic       dataOe_n, intReq_n, txClkOut, txClkOe_n, rxData, rxClk, clrSend, dataSetReady, carrierDetect;
  logic       ringIn, sendDataA, sendDataB, sendDataOe_n, termTimA, termTimB, termTimOe_n, termTimInB;
  logic       adapter_config_clock_out, sendTimB, sendTimOe_n, ctrlOe_n, rxDataB, rxTimB, busy, prevOe, prevClk;
  logic [7:0] regQ[$];
  logic       bitQ[$];
  integer     seed = 32'hF13D242C;
  int         miscompares = 0, totalChecks = 0;
  localparam logic [9:0] TBL [11] = '{
    {PROTO_V35, LVL_RS422, LVL_RS232, LVL_RS232}, {PROTO_RS449, LVL_RS422, LVL_RS422, LVL_RS423},
    {PROTO_EIA530, LVL_RS422, LVL_RS422, LVL_RS423}, {PROTO_RS232, LVL_RS232, LVL_RS232, LVL_RS232},
    {PROTO_RS423, LVL_RS423, LVL_RS423, LVL_RS423}, {PROTO_RS485, LVL_RS422, LVL_RS422, LVL_RS422},
    {PROTO_MIL188C, LVL_RS232, LVL_RS232, LVL_RS232}, {PROTO_EIA562, LVL_RS232, LVL_RS232, LVL_RS232},
    {PROTO_RS422, LVL_RS422, LVL_RS422, LVL_RS422}, {PROTO_MILBAL, LVL_RS422, LVL_RS422, LVL_RS422},
    {PROTO_MILUNB, LVL_RS423, LVL_RS423, LVL_RS423}};
  serial_port_ctrl dut_u (.*);
  line_partner pt_u (.*);
  always #10 clk_sys = !clk_sys;
  task report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  // One register access; for a selected read the byte given is the expected answer.
  task bus(input logic [3:0] a, input logic [7:0] d, input logic c, input logic rd);
    wt(1);
    addr = a;
    dataIn = d;
    chipSelect_n = c;
    readStrobe_n = !rd;
    write_strobe_n = rd;
    if (rd && !c) regQ.push_back(d);
    wt(6);
    chipSelect_n = 1'h1;
    readStrobe_n = 1'h1;
    write_strobe_n = 1'h1;
    wt(5);
  endtask : bus
  always @(posedge clk_sys) begin
    #1;
    txData = 1'($random(seed));
    txClkIn = 1'($random(seed));
    adapter_serial_data_in = 1'($random(seed));
  end
  always @(posedge clk_sys) begin
    prevOe <= dataOe_n;
    prevClk <= rxClk;
    if (prevOe === 1'h1 && dataOe_n === 1'h0) chk(dataOut, regQ.size() > 0 ? regQ.pop_front() : 8'hXX);
    if (prevClk === 1'h0 && rxClk === 1'h1) chk({7'h0, rxData}, {7'h0, bitQ.size() > 0 ? bitQ.pop_front() : 1'hX});
  end
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    wt(3);
    rst_n = 1'h1;
    wt(3);
    chk({1'h0, txClkOe_n, termTimOe_n, sendTimOe_n, sendDataOe_n, ctrlOe_n, dataOe_n, intReq_n}, 8'h7F);
    bus(ADDR_CONFIG, 8'h01, 1'h0, 1'h0);
    chk({7'h0, sendDataOe_n}, 8'h01);
    r = 8'($random(seed));
    bus(ADDR_OUT_MODE, r, 1'h0, 1'h0);
    bus(ADDR_OUT_MODE, r & READ_MASK_OUT_MODE, 1'h0, 1'h1);
    bus(ADDR_OUT_MODE, ~r, 1'h1, 1'h0);
    bus(ADDR_OUT_MODE, r & READ_MASK_OUT_MODE, 1'h0, 1'h1);
    bus(4'hF, 8'h00, 1'h0, 1'h1);
    bus(ADDR_OUT_MODE, 8'h00, 1'h1, 1'h1);
    for (int i = 0; i < 11; i++) begin
      bus(ADDR_OUT_MODE, {4'h8, TBL[i][9:6]}, 1'h0, 1'h0);
      chk({2'h0, lvlData, lvlReqSend, lvlRemLoop}, {2'h0, TBL[i][5:0]});
      chk({2'h0, lvlClk, lvlTermRdy, lvlLocLoop}, {2'h0, TBL[i][5:0]});
      chk({7'h0, sendDataOe_n}, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      {locLoop, remLoop, termReady, reqSend} = 4'($random(seed));
      wt(6);
      chk({ctrlA, ctrlB}, {~locLoop, ~remLoop, ~termReady, ~reqSend, locLoop, remLoop, termReady, reqSend});
    end
    bus(ADDR_LINE_CFG, 8'h01, 1'h0, 1'h0);
    bus(ADDR_REQ_SEND, 8'h01, 1'h0, 1'h0);
    reqSend = 1'h0;
    wt(6);
    chk({7'h0, ctrlB[0]}, 8'h01);
    bus(ADDR_OUT_MODE, 8'h04, 1'h0, 1'h0);
    termReady = 1'h0;
    wt(6);
    chk({7'h0, sendDataOe_n}, 8'h01);
    termReady = 1'h1;
    wt(6);
    chk({7'h0, sendDataOe_n}, 8'h00);
    bus(ADDR_IN_MODE, 8'h40, 1'h0, 1'h0);
    chk({5'h0, txClkOe_n, termTimOe_n, sendTimOe_n}, 8'h02);
    bus(ADDR_IN_MODE, 8'hC0, 1'h0, 1'h0);
    bus(ADDR_CONFIG, 8'h81, 1'h0, 1'h0);
    chk({6'h0, adapter_config_clock_out, sendTimOe_n}, 8'h03);
    for (int n = 0; n < 2; n++) begin
      byteIn = 8'($random(seed));
      for (int b = 7; b >= 0; b--) bitQ.push_back(byteIn[b]);
      go = 1'h1;
      wt(1);
      go = 1'h0;
      for (int k = 0; k < 100 && busy; k++) wt(1);
      wt(8);
    end
    bus(ADDR_INT_CAUSE, 8'hFF, 1'h0, 1'h0);
    statIn = 4'h5;
    wt(8);
    chk({7'h0, intReq_n}, 8'h00);
    chk({4'h0, ringIn, carrierDetect, dataSetReady, clrSend}, 8'h05);
    bus(ADDR_INT_CAUSE, 8'h05, 1'h0, 1'h1);
    bus(ADDR_INT_CAUSE, 8'hF0, 1'h0, 1'h0);
    chk({7'h0, intReq_n}, 8'h01);
    statIn = 4'h0;
    wt(8);
    chk({7'h0, intReq_n}, 8'h01);
    bus(ADDR_INT_CAUSE, 8'h0F, 1'h0, 1'h0);
    statIn = 4'h2;
    wt(8);
    chk({7'h0, intReq_n}, 8'h00);
    rst_n = 1'h0;
    wt(3);
    chk({1'h0, txClkOe_n, termTimOe_n, sendTimOe_n, sendDataOe_n, ctrlOe_n, dataOe_n, intReq_n}, 8'h7F);
    rst_n = 1'h1;
    wt(3);
    bus(ADDR_CONFIG, 8'h01, 1'h0, 1'h0);
    external_control_select = 1'h1;
    extOutMode = 8'h8C;
    wt(6);
    chk({7'h0, sendDataOe_n}, 8'h00);
    extOutMode = 8'h00;
    wt(6);
    chk({7'h0, sendDataOe_n}, 8'h01);
    report_and_stop();
  end
endmodule : tb_serial_port_ctrl
